/* adc_track_start_and_ref_ctrl_bench.sv */
/*
 * Bench for atsrc_ctrl: register model and track/start timing checks.
 * Assumes atsrc_pkg and the converter model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_track_start_and_ref_ctrl_bench;
   import atsrc_pkg::*;
   logic       clk_in = 0, rst_in = 1, wr = 0, dly = 0, pmode = 0;
   logic       itrig = 0, pin = 0, done, trk, start, busy, gnd, temp, bias;
   logic [7:0] addr = 0, wdata = 0, rdata, a, f;
   logic [3:0] lat = 4'h1;
   logic [1:0] vsel;
   int         err_count = 0, checks_done = 0, ref_model, n, i;
   always #12.5 clk_in = ~clk_in;
   atsrc_ctrl uut (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(addr),
      .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rdata_out(rdata),
      .delayed_track_enable_in(dly), .use_pin_start_in(pmode),
      .internal_start_in(itrig), .external_convert_start_in(pin),
      .convert_done_in(done), .track_out(trk), .convert_start_out(start),
      .busy_out(busy), .ground_ref_select_out(gnd),
      .voltage_ref_select_out(vsel), .temp_sensor_enable_out(temp),
      .bias_generator_enable_out(bias));
   atsrc_conv_model conv (.clk_in(clk_in), .rst_in(rst_in),
      .start_in(start), .lat_in(lat), .done_out(done));
   task automatic chk(input string what, input logic [7:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // trigger taken at the current edge; count edges until start is seen,
   // the registered start pulse stands only one cycle; a hang ends the run
   task automatic run(input int expc);
      #1 n = 1;
      while (start !== 1'b1 && n < 20) begin
         if (dly) chk("track_delay", {7'h00, trk}, 8'h01);
         @(posedge clk_in);
         #1 n++;
      end
      if (expc > 0) chk("latency", 8'(n), 8'(expc));
      chk("busy_track", {6'h00, busy, trk}, 8'h02);
      for (i = 0; busy !== 1'b0 && i < 40; i++) begin
         @(posedge clk_in);
         #1;
      end
      if (busy !== 1'b0 || n >= 20) begin
         err_count++;
         test_done();
      end
   endtask
   initial begin
      void'($urandom(32'hb2e94821));
      repeat (5) @(posedge clk_in);
      rst_in <= 0;
      addr <= ATSRC_REF_ADDR;
      ref_model = ATSRC_REF_RESET;
      @(posedge clk_in);
      #1 chk("reset", rdata, 8'(ref_model));
      chk("reset_out", {5'h00, busy, start, trk}, 8'h01);
      // random writes, some to unmapped places; reserved bits stay zero
      repeat (24) begin
         @(posedge clk_in);
         a = 8'($urandom);
         if ($urandom % 3 != 0) a = ATSRC_REF_ADDR;
         addr <= a;
         wdata <= 8'($urandom);
         wr <= 1;
         @(posedge clk_in);
         if (a == ATSRC_REF_ADDR) ref_model = wdata & 8'h3e;
         wr <= 0;
         addr <= ATSRC_REF_ADDR;
         #1 chk("rdata", rdata, 8'(ref_model));
         f = {2'h0, gnd, vsel, temp, bias, 1'b0};
         chk("fields", f, 8'(ref_model));
      end
      @(posedge clk_in);
      addr <= 8'hd3;
      #1 chk("unmapped", rdata, 8'h00);
      $display("register test done");
      // internal trigger, delay off then on, random converter latency
      for (int d = 0; d < 4; d++) begin
         @(posedge clk_in);
         dly <= d[0];
         lat <= 4'(1 + $urandom % 8);
         itrig <= 1;
         @(posedge clk_in);
         itrig <= 0;
         run(d[0] ? 4 : 1);
         chk("track_idle", {7'h00, trk}, 8'h01);
      end
      $display("internal trigger test done");
      // pin trigger: track follows the pin only with delay off
      for (int d = 0; d < 2; d++) begin
         @(posedge clk_in);
         pmode <= 1;
         dly <= d[0];
         pin <= 0;
         repeat (4) @(posedge clk_in);
         #1 chk("pin_low", {7'h00, trk}, 8'h01);
         @(posedge clk_in);
         pin <= 1;
         run(0);
         repeat (3) @(posedge clk_in);
         #1 chk("pin_high", {7'h00, trk}, {7'h00, d[0]});
         @(posedge clk_in);
         pin <= 0;
      end
      $display("pin trigger test done");
      test_done();
   end
endmodule
`default_nettype wire

/* atsrc_conv_model.sv */
/*
 * atsrc_conv_model: behavioural converter front end, far side of the block.
 * Assumes one start pulse per conversion; lat_in sets conversion length.
 */
`timescale 1ns/1ps
`default_nettype none
module atsrc_conv_model (
   input  wire logic       clk_in,   // SAR clock
   input  wire logic       rst_in,   // sync reset, active high
   input  wire logic       start_in, // conversion start pulse
   input  wire logic [3:0] lat_in,   // cycles per conversion, 1 = prompt
   output logic            done_out  // one-cycle end pulse
);
   int cnt;
   // count a conversion down; a slow latency stretches busy for the bench
   always_ff @(posedge clk_in) begin
      done_out <= 1'b0;
      if (rst_in) begin
         cnt <= 0;
      end else if (start_in) begin
         cnt <= int'(lat_in);
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         done_out <= (cnt == 1);
      end
   end
endmodule
`default_nettype wire

/* atsrc_ctrl.sv */
/*
 * atsrc_ctrl: decides when the converter tracks and when a conversion
 * starts, and holds the reference control register.
 * Assumes: clk_in is the SAR clock; the converter reports the end of a
 * conversion with a one-cycle pulse; the start pin is asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - delayed mode holds conversion start three SAR cycles, still tracking.
// - with delayed mode off, conversion starts at once on the trigger.
// - internal triggers: track whenever no conversion is running.
// - pin trigger: track if delayed mode, else only while pin is low.
// - bit 5 selects ground reference: ground pin or analog ground pin.
// - bits 4:3 select the voltage reference source.
// - bit 2 enables the temperature sensor.
// - bit 1 enables the analog bias generator.
// - bits 7:6 and 0 read zero and ignore writes.
module atsrc_ctrl (
   input  wire logic       clk_in,             // SAR clock
   input  wire logic       rst_in,             // sync reset, active high
   input  wire logic [7:0] sfr_addr_in,        // register address
   input  wire logic [7:0] sfr_wdata_in,       // write data
   input  wire logic       sfr_wr_in,          // write strobe
   output logic      [7:0] sfr_rdata_out,      // read data
   input  wire logic       delayed_track_enable_in, // delayed mode bit
   input  wire logic       use_pin_start_in,   // 1: pin is the trigger
   input  wire logic       internal_start_in,  // internal trigger pulse
   input  wire logic       external_convert_start_in, // async start pin
   input  wire logic       convert_done_in,    // conversion end pulse
   output logic            track_out,          // converter tracks input
   output logic            convert_start_out,  // one-cycle start pulse
   output logic            busy_out,           // conversion running
   output logic            ground_ref_select_out,    // 1: analog ground
   output logic      [1:0] voltage_ref_select_out,   // reference source
   output logic            temp_sensor_enable_out,   // sensor on
   output logic            bias_generator_enable_out // bias on
);
   import atsrc_pkg::*;

   logic [7:0]   reference_control;
   logic         pin_meta;
   logic         pin_sync;
   logic         pin_prev;
   logic [1:0]   delay_count;
   atsrc_state_t state;
   atsrc_state_t next_state;
   logic         trigger;
   logic         next_start;

   // start pin passes two flops before anything reads it
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_meta <= external_convert_start_in;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // pin trigger is the rising edge; internal trigger is the pulse
   assign trigger = use_pin_start_in ? (pin_sync & ~pin_prev)
                                     : internal_start_in;

   // register write; only the defined bits take the data
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         reference_control <= ATSRC_REF_RESET;
      end else if (sfr_wr_in && sfr_addr_in == ATSRC_REF_ADDR) begin
         reference_control <= sfr_wdata_in & ATSRC_REF_MASK;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      if (sfr_addr_in == ATSRC_REF_ADDR) begin
         sfr_rdata_out = reference_control;
      end else begin
         sfr_rdata_out = 8'h00;
      end
   end

   assign ground_ref_select_out  = reference_control[ATSRC_GND_BIT];
   assign voltage_ref_select_out =
      reference_control[ATSRC_VSEL_HI:ATSRC_VSEL_LO];
   assign temp_sensor_enable_out = reference_control[ATSRC_TEMP_BIT];
   assign bias_generator_enable_out = reference_control[ATSRC_BIAS_BIT];

   // sequencer; triggers during a delay or conversion are ignored
   always_comb begin
      next_state = state;
      next_start = 1'b0;
      case (state)
         ATSRC_IDLE: begin
            if (trigger) begin
               if (delayed_track_enable_in) begin
                  next_state = ATSRC_DELAY;
               end else begin
                  next_state = ATSRC_CONVERT;
                  next_start = 1'b1;
               end
            end
         end
         ATSRC_DELAY: begin
            if (delay_count == 2'd1) begin
               next_state = ATSRC_CONVERT;
               next_start = 1'b1;
            end
         end
         ATSRC_CONVERT: begin
            if (convert_done_in) begin
               next_state = ATSRC_IDLE;
            end
         end
         default: next_state = ATSRC_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state <= ATSRC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         delay_count <= 2'd0;
      end else if (state == ATSRC_IDLE && trigger) begin
         delay_count <= ATSRC_DELAY_LOAD;
      end else if (delay_count != 2'd0) begin
         delay_count <= delay_count - 2'd1;
      end
   end

   // start pulse from a flop; it lands on the first converting cycle
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         convert_start_out <= 1'b0;
      end else begin
         convert_start_out <= next_start;
      end
   end

   assign busy_out = (state == ATSRC_CONVERT);

   // tracking: never while converting; pin mode without delay needs pin low
   always_comb begin
      if (state == ATSRC_CONVERT) begin
         track_out = 1'b0;
      end else if (use_pin_start_in && !delayed_track_enable_in) begin
         // track only while pin held low
         track_out = ~pin_sync;
      end else begin
         // track when idle or in the delay
         track_out = 1'b1;
      end
   end

   // start seen at the fourth edge: three extra tracking cycles
   a_delay_start_time: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (state == ATSRC_IDLE && trigger && delayed_track_enable_in)
      |-> !convert_start_out [*4] ##1 convert_start_out)
      else $error("delayed start not three cycles after trigger");

   a_direct_start: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (state == ATSRC_IDLE && trigger && !delayed_track_enable_in)
      |=> convert_start_out && busy_out)
      else $error("direct start missing");

   a_delay_tracks: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (state == ATSRC_DELAY) |-> track_out)
      else $error("not tracking during delay");

   a_internal_track: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (!use_pin_start_in && !busy_out) |-> track_out)
      else $error("internal source idle without tracking");

   // pin mode without delay follows the pin
   a_pin_track: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (use_pin_start_in && !delayed_track_enable_in && !busy_out)
      |-> (track_out == !pin_sync))
      else $error("pin mode tracking wrong");

   // unused bits never read back set
   a_unused_zero: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (reference_control & ~ATSRC_REF_MASK) == 8'h00)
      else $error("unused reference bits set");

   // ground select follows the written bit
   a_gnd_write: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (sfr_wr_in && sfr_addr_in == ATSRC_REF_ADDR)
      |=> ground_ref_select_out == $past(sfr_wdata_in[ATSRC_GND_BIT]))
      else $error("ground reference select not written");

   // write reaches reference select a cycle later
   a_vsel_write: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (sfr_wr_in && sfr_addr_in == ATSRC_REF_ADDR)
      |=> voltage_ref_select_out == $past(sfr_wdata_in[4:3]))
      else $error("voltage reference select not written");

   a_enable_write: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (sfr_wr_in && sfr_addr_in == ATSRC_REF_ADDR)
      |=> temp_sensor_enable_out == $past(sfr_wdata_in[2])
          && bias_generator_enable_out == $past(sfr_wdata_in[1]))
      else $error("enable bits not written");

   // counter never reads zero while in the delay state
   a_count_range: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (state == ATSRC_DELAY) |-> delay_count != 2'd0)
      else $error("delay counter empty while delaying");
endmodule

`default_nettype wire

/* atsrc_pkg.sv */
/*
 * atsrc_pkg: constants for the converter track/start and reference control.
 * Assumes a single SAR-clock domain and an 8-bit SFR-style register port.
 */
package atsrc_pkg;
   // reference control register address on the SFR bus
   localparam logic [7:0] ATSRC_REF_ADDR   = 8'hd2;
   // field positions inside the reference control register
   localparam int         ATSRC_GND_BIT    = 5;
   localparam int         ATSRC_VSEL_HI    = 4;
   localparam int         ATSRC_VSEL_LO    = 3;
   localparam int         ATSRC_TEMP_BIT   = 2;
   localparam int         ATSRC_BIAS_BIT   = 1;
   // writable bits: 5:1; bits 7:6 and 0 read zero
   localparam logic [7:0] ATSRC_REF_MASK   = 8'h3e;
   // reset value: voltage reference select = 10
   localparam logic [7:0] ATSRC_REF_RESET  = 8'h10;
   // extra tracking time in SAR clock cycles when delayed mode is on
   localparam int         ATSRC_DELAY_CYC  = 3;
   localparam logic [1:0] ATSRC_DELAY_LOAD = 2'(ATSRC_DELAY_CYC);

   typedef enum logic [1:0] {
      ATSRC_IDLE,
      ATSRC_DELAY,
      ATSRC_CONVERT
   } atsrc_state_t;
endpackage
